// *** bvd_pkg.sv ***
// constants for the battery voltage detect register bank
// assumes a 32-bit apb slave with byte addresses and a 25 MHz pclk
`default_nettype none
package bvd_pkg;

    // register byte offsets
    localparam logic [11:0] BVD_CTRL_OFFS    = 12'h000;
    localparam logic [11:0] BVD_CFG_OFFS     = 12'h004;
    localparam logic [11:0] BVD_STATUS_OFFS  = 12'h008;

    // control register fields
    localparam int          BVD_CTRL_LOW_IE  = 3;
    localparam int          BVD_CTRL_ULOW_IE = 2;
    localparam int          BVD_CTRL_MON_SEL = 1;
    localparam int          BVD_CTRL_BIT0    = 0;
    localparam int          BVD_CTRL_W       = 4;
    localparam logic [3:0]  BVD_CTRL_RESET   = 4'h0;

    // configuration register fields
    localparam int          BVD_CFG_W        = 2;
    localparam logic [1:0]  BVD_CFG_RESET    = 2'h2;

    // status register fields
    localparam int          BVD_STAT_LOW     = 1;
    localparam int          BVD_STAT_ULOW    = 0;
    localparam int          BVD_STAT_W       = 2;
    localparam logic [1:0]  BVD_STAT_RESET   = 2'h0;

    // thresholds in millivolts
    localparam logic [11:0] BVD_MON_BASE_MV  = 12'd1700;
    localparam logic [11:0] BVD_MON_STEP_MV  = 12'd100;
    localparam logic [11:0] BVD_HP_ULOW_MV   = 12'd1700;
    localparam logic [11:0] BVD_HP_LOW_MV    = 12'd1950;
    localparam logic [11:0] BVD_HP_STEP_MV   = 12'd200;

    // synchroniser depth for comparator results
    localparam int          BVD_SYNC_STAGES  = 2;

    // register selector
    typedef enum logic [1:0] {
        BVD_SEL_NONE   = 2'b00,
        BVD_SEL_CTRL   = 2'b01,
        BVD_SEL_CFG    = 2'b10,
        BVD_SEL_STATUS = 2'b11
    } bvd_sel_e;

endpackage
`default_nettype wire

// *** bvd_sync2.sv ***
// two-stage synchroniser for asynchronous comparator levels
// assumes pclk domain and asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module bvd_sync2 #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // levels
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;

    // first stage is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// *** bvd_regs.sv ***
// battery voltage detect register bank with apb slave
// assumes analog comparator results arrive asynchronously
//
// Notes on behaviour
// - control bit 3 enables low-voltage interrupt, reset clear.
// - control bit 2 enables ultra-low-voltage interrupt, reset clear.
// - control bit 1 set selects low-power monitor, clear selects precision path.
// - in monitor mode control bit 0 is threshold code msb.
// - in precision mode control bit 0 enables detector and references.
// - config bits 1:0 pick paired precision thresholds, reset to 10.
// - monitor threshold 1.7 V at 000 to 2.4 V at 111, 0.1 V steps.
// - status bit 1 shows battery below low threshold of active path.
// - status bit 0 shows below ultra-low only in precision mode.
// - ultra-low with both enables set raises nmi instead of ordinary irq.
`timescale 1ns/1ps
`default_nettype none
module bvd_regs
    import bvd_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic        pready,
    output var  logic [31:0] prdata,
    output var  logic        pslverr,
    // analog comparator results
    input  wire logic        ana_below_low,
    input  wire logic        ana_below_ultra_low,
    // analog controls
    output var  logic        lowpower_monitor_select,
    output var  logic        precision_detector_enable,
    output var  logic [2:0]  monitor_code,
    output var  logic [1:0]  hp_threshold_sel,
    output var  logic [11:0] low_thresh_mv,
    output var  logic [11:0] ultra_thresh_mv,
    // interrupts
    output var  logic        irq_maskable,
    output var  logic        irq_nmi
);

    logic [BVD_CTRL_W-1:0] ctrl_reg;
    logic [BVD_CFG_W-1:0]  cfg_reg;
    logic [BVD_STAT_W-1:0] status_reg;
    logic [BVD_STAT_W-1:0] status_next;
    logic [1:0]            cmp_sync;
    logic                  access;
    logic                  xfer_done;
    bvd_sel_e              sel;
    logic [31:0]           rd_next;
    logic                  mon_mode;
    logic                  det_on;
    logic                  nmi_next;
    logic                  irq_next;

    function automatic bvd_sel_e decode(input logic [11:0] a);
        unique case (a)
            BVD_CTRL_OFFS:   decode = BVD_SEL_CTRL;
            BVD_CFG_OFFS:    decode = BVD_SEL_CFG;
            BVD_STATUS_OFFS: decode = BVD_SEL_STATUS;
            default:         decode = BVD_SEL_NONE;
        endcase
    endfunction

    function automatic logic [11:0] low_mv(input logic mon, input logic [2:0] code);
        if (mon) begin
            low_mv = 12'(BVD_MON_BASE_MV + BVD_MON_STEP_MV * code);
        end else begin
            low_mv = 12'(BVD_HP_LOW_MV + BVD_HP_STEP_MV * code[1:0]);
        end
    endfunction

    // comparator levels cross into pclk
    bvd_sync2 #(
        .W (2)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({ana_below_low, ana_below_ultra_low}),
        .sync_out (cmp_sync)
    );

    // apb handshake, one wait state
    assign access    = psel && penable;
    assign xfer_done = access && pready;
    assign sel       = decode(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access && !pready;
        end
    end

    // read mux, reserved bits zero
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (sel)
            BVD_SEL_CTRL:   rd_next[BVD_CTRL_W-1:0] = ctrl_reg;
            BVD_SEL_CFG:    rd_next[BVD_CFG_W-1:0]  = cfg_reg;
            BVD_SEL_STATUS: rd_next[BVD_STAT_W-1:0] = status_reg;
            BVD_SEL_NONE:   rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_next;
            pslverr <= (sel == BVD_SEL_NONE);
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= BVD_CTRL_RESET;
        end else if (xfer_done && pwrite && pstrb[0] && sel == BVD_SEL_CTRL) begin
            ctrl_reg <= pwdata[BVD_CTRL_W-1:0];
        end
    end

    // configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= BVD_CFG_RESET;
        end else if (xfer_done && pwrite && pstrb[0] && sel == BVD_SEL_CFG) begin
            cfg_reg <= pwdata[BVD_CFG_W-1:0];
        end
    end

    assign mon_mode = ctrl_reg[BVD_CTRL_MON_SEL];
    assign det_on   = !mon_mode && ctrl_reg[BVD_CTRL_BIT0];

    // analog controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lowpower_monitor_select   <= 1'b0;
            precision_detector_enable <= 1'b0;
            monitor_code              <= 3'h0;
            hp_threshold_sel          <= BVD_CFG_RESET;
        end else begin
            lowpower_monitor_select   <= mon_mode;
            precision_detector_enable <= det_on;
            monitor_code              <= mon_mode ? {ctrl_reg[BVD_CTRL_BIT0], cfg_reg}
                                                  : 3'h0;
            hp_threshold_sel          <= cfg_reg;
        end
    end

    // thresholds in effect, for software and trim
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_thresh_mv   <= 12'h000;
            ultra_thresh_mv <= 12'h000;
        end else begin
            low_thresh_mv   <= low_mv(mon_mode, {ctrl_reg[BVD_CTRL_BIT0], cfg_reg});
            ultra_thresh_mv <= mon_mode ? 12'h000
                             : 12'(BVD_HP_ULOW_MV + BVD_HP_STEP_MV * cfg_reg);
        end
    end

    // status follows the active path only
    always_comb begin
        status_next                = BVD_STAT_RESET;
        status_next[BVD_STAT_LOW]  = cmp_sync[1] && (mon_mode || det_on);
        status_next[BVD_STAT_ULOW] = cmp_sync[0] && det_on;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= BVD_STAT_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // nmi takes the place of the ordinary irq
    assign nmi_next = status_reg[BVD_STAT_ULOW] && ctrl_reg[BVD_CTRL_ULOW_IE]
                      && ctrl_reg[BVD_CTRL_LOW_IE];
    assign irq_next = !nmi_next
                      && ((status_reg[BVD_STAT_LOW] && ctrl_reg[BVD_CTRL_LOW_IE])
                      || (status_reg[BVD_STAT_ULOW] && ctrl_reg[BVD_CTRL_ULOW_IE]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_maskable <= 1'b0;
            irq_nmi      <= 1'b0;
        end else begin
            irq_maskable <= irq_next;
            irq_nmi      <= nmi_next;
        end
    end

    // checks
    sequence s_wr_ctrl;
        xfer_done && pwrite && pstrb[0] && sel == BVD_SEL_CTRL;
    endsequence

    sequence s_rd_setup(bvd_sel_e s);
        psel && !penable && !pwrite && sel == s;
    endsequence

    property p_low_irq;
        @(posedge pclk) disable iff (!presetn)
        status_reg[BVD_STAT_LOW] && ctrl_reg[BVD_CTRL_LOW_IE]
            && !ctrl_reg[BVD_CTRL_ULOW_IE] |=> irq_maskable && !irq_nmi;
    endproperty
    a_low_irq: assert property (p_low_irq) else $error("low irq missing");

    property p_ulow_irq;
        @(posedge pclk) disable iff (!presetn)
        status_reg[BVD_STAT_ULOW] && ctrl_reg[BVD_CTRL_ULOW_IE]
            && !ctrl_reg[BVD_CTRL_LOW_IE] |=> irq_maskable && !irq_nmi;
    endproperty
    a_ulow_irq: assert property (p_ulow_irq) else $error("ultra-low irq missing");

    property p_mon_sel;
        @(posedge pclk) disable iff (!presetn)
        s_wr_ctrl |=> ##1 lowpower_monitor_select == $past(pwdata[BVD_CTRL_MON_SEL], 2);
    endproperty
    a_mon_sel: assert property (p_mon_sel) else $error("monitor select wrong");

    property p_mon_code;
        @(posedge pclk) disable iff (!presetn)
        mon_mode |=> monitor_code == {$past(ctrl_reg[BVD_CTRL_BIT0]), $past(cfg_reg)}
                     && !precision_detector_enable;
    endproperty
    a_mon_code: assert property (p_mon_code) else $error("monitor code wrong");

    property p_det_en;
        @(posedge pclk) disable iff (!presetn)
        !mon_mode |=> precision_detector_enable == $past(ctrl_reg[BVD_CTRL_BIT0]);
    endproperty
    a_det_en: assert property (p_det_en) else $error("detector enable wrong");

    property p_hp_thr;
        @(posedge pclk) disable iff (!presetn)
        !mon_mode && cfg_reg == 2'h3 |=> low_thresh_mv == 12'd2550
                                         && ultra_thresh_mv == 12'd2300;
    endproperty
    a_hp_thr: assert property (p_hp_thr) else $error("precision threshold wrong");

    property p_mon_thr;
        @(posedge pclk) disable iff (!presetn)
        mon_mode && ctrl_reg[BVD_CTRL_BIT0] && cfg_reg == 2'h3 |=> low_thresh_mv == 12'd2400;
    endproperty
    a_mon_thr: assert property (p_mon_thr) else $error("monitor threshold wrong");

    property p_low_flag;
        @(posedge pclk) disable iff (!presetn)
        (ana_below_low && mon_mode) [*3] |=> status_reg[BVD_STAT_LOW];
    endproperty
    a_low_flag: assert property (p_low_flag) else $error("low flag missing");

    property p_ulow_flag;
        @(posedge pclk) disable iff (!presetn)
        mon_mode |=> !status_reg[BVD_STAT_ULOW];
    endproperty
    a_ulow_flag: assert property (p_ulow_flag) else $error("ultra flag in monitor mode");

    property p_nmi;
        @(posedge pclk) disable iff (!presetn)
        status_reg[BVD_STAT_ULOW] && ctrl_reg[BVD_CTRL_ULOW_IE]
            && ctrl_reg[BVD_CTRL_LOW_IE] |=> irq_nmi && !irq_maskable;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not raised");

    property p_irq_cause;
        @(posedge pclk) disable iff (!presetn)
        irq_maskable |-> $past(status_reg[BVD_STAT_LOW] && ctrl_reg[BVD_CTRL_LOW_IE]
                          || status_reg[BVD_STAT_ULOW] && ctrl_reg[BVD_CTRL_ULOW_IE]);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

    property p_rsvd_ctrl;
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup(BVD_SEL_CTRL) ##1 access [*2] |-> prdata[31:BVD_CTRL_W] == 28'h0 && pready;
    endproperty
    a_rsvd_ctrl: assert property (p_rsvd_ctrl) else $error("ctrl reserved bits set");

    property p_rsvd_cfg;
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup(BVD_SEL_CFG) ##1 access [*2] |-> prdata[31:BVD_CFG_W] == 30'h0
                                                  && prdata[1:0] == cfg_reg;
    endproperty
    a_rsvd_cfg: assert property (p_rsvd_cfg) else $error("cfg read wrong");

    property p_ready_timing;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable ##1 access |-> !pready ##1 pready;
    endproperty
    a_ready_timing: assert property (p_ready_timing) else $error("pready timing wrong");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && sel == BVD_SEL_NONE ##1 access [*2]
            |-> pslverr && pready && prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_ctrl_hold;
        @(posedge pclk) disable iff (!presetn)
        !(xfer_done && pwrite && pstrb[0] && sel == BVD_SEL_CTRL) |=> $stable(ctrl_reg);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctrl not held");

    property p_cfg_hold;
        @(posedge pclk) disable iff (!presetn)
        !(xfer_done && pwrite && pstrb[0] && sel == BVD_SEL_CFG) |=> $stable(cfg_reg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("cfg not held");

    property p_ulow_set;
        @(posedge pclk) disable iff (!presetn)
        (ana_below_ultra_low && det_on) [*3] |=> status_reg[BVD_STAT_ULOW];
    endproperty
    a_ulow_set: assert property (p_ulow_set) else $error("ultra flag missing");

    property p_low_clear;
        @(posedge pclk) disable iff (!presetn)
        (!ana_below_low) [*3] |=> !status_reg[BVD_STAT_LOW];
    endproperty
    a_low_clear: assert property (p_low_clear) else $error("low flag stuck");

    property p_rd_status;
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup(BVD_SEL_STATUS) ##1 access [*2]
            |-> prdata == {30'h0, $past(status_reg)};
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong");

    property p_irq_off;
        @(posedge pclk) disable iff (!presetn)
        !status_reg[BVD_STAT_LOW] && !status_reg[BVD_STAT_ULOW] |=> !irq_maskable && !irq_nmi;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq without status");

endmodule
`default_nettype wire

// *** bvd_regs_tb_top.sv ***
// self-checking testbench for the battery voltage detect register bank
// assumes bvd_pkg and bvd_regs are compiled first; apb master driven here
`timescale 1ns/1ps
`default_nettype none
module bvd_regs_tb_top
    import bvd_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        ana_below_low;
    logic        ana_below_ultra_low;
    logic        lowpower_monitor_select;
    logic        precision_detector_enable;
    logic [2:0]  monitor_code;
    logic [1:0]  hp_threshold_sel;
    logic [11:0] low_thresh_mv;
    logic [11:0] ultra_thresh_mv;
    logic        irq_maskable;
    logic        irq_nmi;
    int          failures;
    int          cmp_count;
    logic [31:0] rd;
    logic        er;
    // {ctrl, low in, ultra in, status, maskable, nmi}
    logic [9:0]  irq_tab [8] = '{10'h1B8, 10'h26A, 10'h17E, 10'h07C, 10'h37D, 10'h36A, 10'h3AA,
                                 10'h240};

    bvd_regs dut (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .psel                      (psel),
        .penable                   (penable),
        .pwrite                    (pwrite),
        .paddr                     (paddr),
        .pwdata                    (pwdata),
        .pstrb                     (pstrb),
        .pready                    (pready),
        .prdata                    (prdata),
        .pslverr                   (pslverr),
        .ana_below_low             (ana_below_low),
        .ana_below_ultra_low       (ana_below_ultra_low),
        .lowpower_monitor_select   (lowpower_monitor_select),
        .precision_detector_enable (precision_detector_enable),
        .monitor_code              (monitor_code),
        .hp_threshold_sel          (hp_threshold_sel),
        .low_thresh_mv             (low_thresh_mv),
        .ultra_thresh_mv           (ultra_thresh_mv),
        .irq_maskable              (irq_maskable),
        .irq_nmi                   (irq_nmi)
    );

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    task automatic stop_test();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: output %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits for pready, the watchdog bounds the wait
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF, rd, er);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'h0, rd, er);
        chk_reg(rd, exp);
        chk_reg({31'h0, er}, 32'h0);
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        stop_test();
    end

    initial begin
        failures = 0;
        cmp_count = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        ana_below_low = 1'b0;
        ana_below_ultra_low = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk_pin({10'h0, hp_threshold_sel}, 12'h002);
        chk_pin(low_thresh_mv, 12'd2350);
        chk_pin(ultra_thresh_mv, 12'd2100);
        rd_chk(BVD_CTRL_OFFS, 32'h0000_0000);
        rd_chk(BVD_CFG_OFFS, 32'h0000_0002);
        rd_chk(BVD_STATUS_OFFS, 32'h0000_0000);
        // reserved bits and read-only places
        wr(BVD_CTRL_OFFS, 32'hFFFF_FFF0);
        rd_chk(BVD_CTRL_OFFS, 32'h0000_0000);
        wr(BVD_CTRL_OFFS, 32'hFFFF_FFFF);
        rd_chk(BVD_CTRL_OFFS, 32'h0000_000F);
        wr(BVD_CFG_OFFS, 32'hFFFF_FFFF);
        rd_chk(BVD_CFG_OFFS, 32'h0000_0003);
        wr(BVD_STATUS_OFFS, 32'hFFFF_FFFF);
        rd_chk(BVD_STATUS_OFFS, 32'h0000_0000);
        xfer(1'b0, 12'h00C, 32'h0, 4'h0, rd, er);
        chk_reg({rd[31:1], er}, 32'h0000_0001);
        xfer(1'b1, 12'h00C, 32'hFFFF_FFFF, 4'hF, rd, er);
        chk_reg({31'h0, er}, 32'h0000_0001);
        xfer(1'b1, BVD_CFG_OFFS, 32'h0, 4'h0, rd, er);
        rd_chk(BVD_CFG_OFFS, 32'h0000_0003);
        // precision thresholds for each code
        wr(BVD_CTRL_OFFS, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(BVD_CFG_OFFS, 32'(i));
            repeat (3) @(posedge pclk);
            chk_pin(low_thresh_mv, 12'(1950 + 200 * i));
            chk_pin(ultra_thresh_mv, 12'(1700 + 200 * i));
            chk_pin({10'h0, hp_threshold_sel}, 12'(i));
            chk_pin({11'h0, precision_detector_enable}, 12'h001);
            chk_pin({9'h0, monitor_code}, 12'h000);
        end
        // monitor thresholds for each code
        for (int c = 0; c < 8; c++) begin
            wr(BVD_CTRL_OFFS, 32'h2 | 32'(c >> 2));
            wr(BVD_CFG_OFFS, 32'(c & 3));
            repeat (3) @(posedge pclk);
            chk_pin(low_thresh_mv, 12'(1700 + 100 * c));
            chk_pin({9'h0, monitor_code}, 12'(c));
            chk_pin({11'h0, lowpower_monitor_select}, 12'h001);
            chk_pin({11'h0, precision_detector_enable}, 12'h000);
            chk_pin(ultra_thresh_mv, 12'h000);
        end
        // comparator levels to status and interrupts
        for (int k = 0; k < 8; k++) begin
            wr(BVD_CTRL_OFFS, {28'h0, irq_tab[k][9:6]});
            ana_below_low <= irq_tab[k][5];
            ana_below_ultra_low <= irq_tab[k][4];
            repeat (6) @(posedge pclk);
            chk_pin({11'h0, irq_maskable}, {11'h0, irq_tab[k][1]});
            chk_pin({11'h0, irq_nmi}, {11'h0, irq_tab[k][0]});
            rd_chk(BVD_STATUS_OFFS, {30'h0, irq_tab[k][3:2]});
        end
        stop_test();
    end
endmodule
`default_nettype wire
